// ==== rtl/match_based_pwm_unit.sv ====
// Summary of operation
// - Counter advances on peripheral clock; matches act
// - 32-bit counter behind 32-bit prescaler
// - Seven matches: six single or three double
// - Period match resets counter for all outputs
// - Single edge: rise at period, fall at match
// - Double edge: two matches set rise, fall
// - Period and width any whole tick count
// - Match may continue counting, optional interrupt
// - Match may stop or reset, optional interrupt
// - In PWM mode new match values apply only after release
// - Without PWM mode acts as plain timer
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps

module match_based_pwm_unit #(
  parameter int CNT_W   = 32,                 // Counter and prescaler width
  parameter int N_MATCH = 7,                  // Number of match registers
  parameter int N_OUT   = 6                   // Number of PWM outputs
) (
  input  wire logic        clk,               // Peripheral clock, 40 MHz
  input  wire logic        srst,              // Synchronous reset, active high
  input  wire logic [7:0]  addr,              // Register byte address
  input  wire logic [31:0] wdata,             // Register write data
  input  wire logic        wr,                // Write strobe
  input  wire logic        rd,                // Read strobe
  output logic      [31:0] rdata,             // Read data, cycle after rd
  output logic             irq,               // Level interrupt
  output logic [N_OUT-1:0] pwm_out,           // PWM levels, bit 0 is output 1
  output logic [N_OUT-1:0] pwm_oe             // PWM output enables
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [N_MATCH-1:0]               int_status_r;
  logic [N_MATCH-1:0]               int_status_nxt;
  logic [N_MATCH-1:0]               int_enable_r;
  logic [pwm_unit_pkg::TCTRL_W-1:0] tctrl_r;
  logic [CNT_W-1:0]                 count_r;
  logic [CNT_W-1:0]                 count_nxt;
  logic [CNT_W-1:0]                 presc_lim_r;
  logic [CNT_W-1:0]                 presc_cnt_r;
  logic [CNT_W-1:0]                 presc_cnt_nxt;
  logic [3*N_MATCH-1:0]             mctrl_r;
  logic [pwm_unit_pkg::PCTRL_W-1:0] pctrl_r;
  logic [N_OUT-1:0]                 out_r;
  logic [N_OUT-1:0]                 out_nxt;
  logic [31:0]                      rdata_r;
  logic [31:0]                      rdata_nxt;

  logic [N_MATCH-1:0]               hit;
  logic [N_MATCH-1:0]               pending;
  logic [CNT_W-1:0]                 shadow [N_MATCH];
  logic [N_MATCH-1:0]               match_wr;
  logic [N_MATCH-1:0]               int_req;
  logic [N_MATCH-1:0]               rst_req;
  logic [N_MATCH-1:0]               stop_req;
  logic [N_OUT-1:0]                 set_ev;
  logic [N_OUT-1:0]                 clr_ev;
  logic [N_OUT-1:0]                 dbl_sel;

  // ****************************************
  // Address decode
  // ****************************************
  // True when the bus address equals a register offset
  function automatic logic at(input logic [7:0] a, input logic [7:0] ofs);
    at = (a == ofs);
  endfunction

  // True when the bus address equals the offset of match register i
  function automatic logic is_match(input logic [7:0] a, input int i);
    is_match = (a == 8'(pwm_unit_pkg::OFS_MATCH_BASE + 8'(4 * i)));
  endfunction

  wire wr_clear   = wr & at(addr, pwm_unit_pkg::OFS_INT_CLEAR);
  wire wr_enable  = wr & at(addr, pwm_unit_pkg::OFS_INT_ENABLE);
  wire wr_tctrl   = wr & at(addr, pwm_unit_pkg::OFS_TIMER_CTRL);
  wire wr_count   = wr & at(addr, pwm_unit_pkg::OFS_COUNTER);
  wire wr_presc   = wr & at(addr, pwm_unit_pkg::OFS_PRESCALE);
  wire wr_mctrl   = wr & at(addr, pwm_unit_pkg::OFS_MATCH_CTRL);
  wire wr_pctrl   = wr & at(addr, pwm_unit_pkg::OFS_PWM_CTRL);
  wire wr_release = wr & at(addr, pwm_unit_pkg::OFS_RELEASE);

  // ****************************************
  // Control fields
  // ****************************************
  wire run_en    = tctrl_r[pwm_unit_pkg::TCTRL_RUN_BIT];
  wire cnt_hold  = tctrl_r[pwm_unit_pkg::TCTRL_RESET_BIT];
  wire pwm_en    = tctrl_r[pwm_unit_pkg::TCTRL_PWM_BIT];

  // Prescaler reaches its limit: counter advances this cycle
  // prescale tick
  wire tick      = run_en & ~cnt_hold & (presc_cnt_r == presc_lim_r);

  // Per-match actions taken apart from the packed control word
  // continue with interrupt
  genvar g;
  generate
    for (g = 0; g < N_MATCH; g++) begin : g_act
      assign int_req[g]  = mctrl_r[3*g + pwm_unit_pkg::MCTRL_INT_OFS];
      assign rst_req[g]  = mctrl_r[3*g + pwm_unit_pkg::MCTRL_RST_OFS];
      assign stop_req[g] = mctrl_r[3*g + pwm_unit_pkg::MCTRL_STOP_OFS];
      assign match_wr[g] = wr & is_match(addr, g);
    end
  endgenerate

  // In PWM mode the period match always restarts the cycle
  // period reset
  wire period_hit  = hit[0] & pwm_en;
  wire any_reset   = |(hit & rst_req) | period_hit;
  wire any_stop    = |(hit & stop_req);

  // ****************************************
  // Match channels
  // ****************************************
  // Seven shadow/active pairs; timer mode bypasses the release step
  // seven matches
  generate
    for (g = 0; g < N_MATCH; g++) begin : g_chan
      pwm_match_chan #(
        .CNT_W (CNT_W)
      ) u_chan (
        .clk         (clk),
        .srst        (srst),
        .wr_en       (match_wr[g]),
        .wr_data     (wdata[CNT_W-1:0]),
        .release_set (wr_release & wdata[g]),
        .transfer    (period_hit),
        .direct      (~pwm_en),
        .tick        (tick),
        .count       (count_r),
        .shadow      (shadow[g]),
        .pending     (pending[g]),
        .hit         (hit[g])
      );
    end
  endgenerate

  // ****************************************
  // Prescaler and counter
  // ****************************************
  // Prescale counter wraps at its limit, giving limit+1 clocks per tick
  // prescaled counter
  assign presc_cnt_nxt = (cnt_hold | tick) ? '0 :
                         run_en ? presc_cnt_r + 1'b1 : presc_cnt_r;

  // Reset by match beats increment; software write beats both
  // count clock cycles
  assign count_nxt = wr_count ? wdata[CNT_W-1:0] :
                     cnt_hold ? '0 :
                     (tick & any_reset) ? '0 :
                     tick ? count_r + 1'b1 : count_r;

  // Prescaler and counter flops
  always_ff @(posedge clk) begin
    if (srst) begin
      presc_cnt_r <= '0;
      count_r     <= '0;
    end else begin
      presc_cnt_r <= presc_cnt_nxt;
      count_r     <= count_nxt;
    end
  end

  // ****************************************
  // Timer control with stop on match
  // ****************************************
  // A stop match clears the run bit; a software write in the same cycle wins
  // stop on match
  always_ff @(posedge clk) begin
    if (srst) begin
      tctrl_r <= '0;
    end else if (wr_tctrl) begin
      tctrl_r <= wdata[pwm_unit_pkg::TCTRL_W-1:0];
    end else if (any_stop) begin
      tctrl_r[pwm_unit_pkg::TCTRL_RUN_BIT] <= 1'b0;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Prescale limit, match actions, PWM control and interrupt enables
  always_ff @(posedge clk) begin
    if (srst) begin
      presc_lim_r  <= '0;
      mctrl_r      <= '0;
      pctrl_r      <= '0;
      int_enable_r <= '0;
    end else begin
      if (wr_presc) begin
        presc_lim_r <= wdata[CNT_W-1:0];
      end
      if (wr_mctrl) begin
        mctrl_r <= wdata[3*N_MATCH-1:0];
      end
      if (wr_pctrl) begin
        pctrl_r <= wdata[pwm_unit_pkg::PCTRL_W-1:0];
      end
      if (wr_enable) begin
        int_enable_r <= wdata[N_MATCH-1:0];
      end
    end
  end

  // ****************************************
  // PWM edge logic
  // ****************************************
  // Output 1 is always single edge; control bits 1..5 pick double edge for outputs 2..6
  assign dbl_sel = {pctrl_r[pwm_unit_pkg::PCTRL_DBL_LSB + 1 +: N_OUT-1], 1'b0};

  // Single edge: set at period, clear at own match.
  // Double edge: set at previous match, clear at own match.
  // single edge
  generate
    for (g = 0; g < N_OUT; g++) begin : g_edge
      if (g == 0) begin : g_first
        assign set_ev[g] = hit[0];
      end else begin : g_rest
        assign set_ev[g] = dbl_sel[g] ? hit[g] : hit[0];
      end
      assign clr_ev[g] = hit[g+1];
    end
  endgenerate

  // Clear wins over set, so an edge match equal to the period gives constant low
  assign out_nxt = pwm_en ? ((out_r | set_ev) & ~clr_ev) : out_r;

  // Output level flops
  always_ff @(posedge clk) begin
    if (srst) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign pwm_out = out_r;
  assign pwm_oe  = pctrl_r[pwm_unit_pkg::PCTRL_OE_LSB +: N_OUT];

  // ****************************************
  // Interrupt status
  // ****************************************
  // Sticky match flags; a new event wins over a clear in the same cycle
  // match interrupt
  assign int_status_nxt = (int_status_r & ~({N_MATCH{wr_clear}} & wdata[N_MATCH-1:0]))
                          | (hit & int_req);

  // Status flops
  always_ff @(posedge clk) begin
    if (srst) begin
      int_status_r <= '0;
    end else begin
      int_status_r <= int_status_nxt;
    end
  end

  assign irq = |(int_status_r & int_enable_r);

  // ****************************************
  // Read path
  // ****************************************
  // Read mux; unmapped and write-only addresses read as zero
  always_comb begin
    rdata_nxt = pwm_unit_pkg::RST_ZERO;
    if (rd) begin
      unique case (addr)
        pwm_unit_pkg::OFS_INT_STATUS: rdata_nxt = 32'(int_status_r);
        pwm_unit_pkg::OFS_INT_ENABLE: rdata_nxt = 32'(int_enable_r);
        pwm_unit_pkg::OFS_TIMER_CTRL: rdata_nxt = 32'(tctrl_r);
        pwm_unit_pkg::OFS_COUNTER:    rdata_nxt = 32'(count_r);
        pwm_unit_pkg::OFS_PRESCALE:   rdata_nxt = 32'(presc_lim_r);
        pwm_unit_pkg::OFS_PRESC_CNT:  rdata_nxt = 32'(presc_cnt_r);
        pwm_unit_pkg::OFS_MATCH_CTRL: rdata_nxt = 32'(mctrl_r);
        pwm_unit_pkg::OFS_PWM_CTRL:   rdata_nxt = 32'(pctrl_r);
        pwm_unit_pkg::OFS_RELEASE:    rdata_nxt = 32'(pending);
        pwm_unit_pkg::OFS_OUT_STATE:  rdata_nxt = 32'(out_r);
        default: begin
          for (int i = 0; i < N_MATCH; i++) begin
            if (is_match(addr, i)) begin
              rdata_nxt = 32'(shadow[i]);
            end
          end
        end
      endcase
    end
  end

  // Read data register, valid only the cycle after rd
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= pwm_unit_pkg::RST_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

endmodule

// ==== rtl/pwm_match_chan.sv ====
`timescale 1ns/1ps

// Shadow and active copy of one match value, with release handshake
module pwm_match_chan #(
  parameter int CNT_W = 32
) (
  input  wire logic             clk,          // Peripheral clock
  input  wire logic             srst,         // Synchronous reset, active high
  input  wire logic             wr_en,        // Software write of shadow value
  input  wire logic [CNT_W-1:0] wr_data,      // Shadow value to store
  input  wire logic             release_set,  // Software releases the shadow value
  input  wire logic             transfer,     // Period match that resets the counter
  input  wire logic             direct,       // Timer mode: shadow drives compare at once
  input  wire logic             tick,         // Counter advance strobe
  input  wire logic [CNT_W-1:0] count,        // Current counter value
  output logic      [CNT_W-1:0] shadow,       // Shadow value readback
  output logic                  pending,      // Released and not yet transferred
  output logic                  hit           // Match event this cycle
);

  logic [CNT_W-1:0] shadow_r;
  logic [CNT_W-1:0] active_r;
  logic [CNT_W-1:0] active_nxt;
  logic             pending_r;
  logic             pending_nxt;
  logic             load;

  // In PWM mode a released value moves into compare only at the period match
  // load at period
  assign load        = direct | (pending_r & transfer);
  assign active_nxt  = load ? shadow_r : active_r;
  // Release set wins over the clear by transfer
  // release before use
  assign pending_nxt = release_set | (pending_r & ~transfer & ~direct);

  // Match on counter equality at the advance strobe
  // equality compare
  assign hit     = tick & (count == active_r);
  assign shadow  = shadow_r;
  assign pending = pending_r;

  // Shadow, active and pending flops
  always_ff @(posedge clk) begin
    if (srst) begin
      shadow_r  <= '0;
      active_r  <= '0;
      pending_r <= 1'b0;
    end else begin
      if (wr_en) begin
        shadow_r <= wr_data;
      end
      active_r  <= active_nxt;
      pending_r <= pending_nxt;
    end
  end

endmodule

// ==== shared/pwm_unit_pkg.sv ====
package pwm_unit_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int CNT_W      = 32;              // Counter and prescaler width
  localparam int N_MATCH    = 7;               // Match registers, index 0 is the period match
  localparam int N_OUT      = 6;               // PWM outputs, numbered 1..6
  localparam int ADDR_W     = 8;               // Register bus byte address width
  localparam int DATA_W     = 32;              // Register bus data width

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_INT_STATUS  = 8'h00;  // RO sticky match events
  localparam logic [7:0] OFS_INT_CLEAR   = 8'h04;  // WO write one to clear
  localparam logic [7:0] OFS_INT_ENABLE  = 8'h08;  // RW interrupt enables
  localparam logic [7:0] OFS_TIMER_CTRL  = 8'h0c;  // RW counter and mode control
  localparam logic [7:0] OFS_COUNTER     = 8'h10;  // RW timer counter
  localparam logic [7:0] OFS_PRESCALE    = 8'h14;  // RW prescale limit
  localparam logic [7:0] OFS_PRESC_CNT   = 8'h18;  // RO prescale counter
  localparam logic [7:0] OFS_MATCH_CTRL  = 8'h1c;  // RW per-match actions
  localparam logic [7:0] OFS_MATCH_BASE  = 8'h20;  // RW match 0..6 at 0x20..0x38
  localparam logic [7:0] OFS_PWM_CTRL    = 8'h3c;  // RW edge mode and output enables
  localparam logic [7:0] OFS_RELEASE     = 8'h40;  // RW write one to release, read pending
  localparam logic [7:0] OFS_OUT_STATE   = 8'h44;  // RO output levels

  // ****************************************
  // Timer control fields
  // ****************************************
  localparam int TCTRL_RUN_BIT   = 0;          // Counter enable
  localparam int TCTRL_RESET_BIT = 1;          // Hold counter and prescaler at zero
  localparam int TCTRL_PWM_BIT   = 3;          // PWM mode enable
  localparam int TCTRL_W         = 4;

  // ****************************************
  // Match control fields, three bits per match
  // ****************************************
  localparam int MCTRL_INT_OFS   = 0;          // Raise interrupt on match
  localparam int MCTRL_RST_OFS   = 1;          // Reset counter on match
  localparam int MCTRL_STOP_OFS  = 2;          // Stop counter on match
  localparam int MCTRL_FIELD_W   = 3;

  // ****************************************
  // PWM control fields
  // ****************************************
  localparam int PCTRL_DBL_LSB   = 0;          // Bits 1..5 select double edge for outputs 2..6
  localparam int PCTRL_OE_LSB    = 8;          // Bits 8..13 enable outputs 1..6
  localparam int PCTRL_W         = 14;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

endpackage

// ==== testbench/match_based_pwm_unit_tb_top.sv ====
`timescale 1ns/1ps

module match_based_pwm_unit_tb_top;
  typedef struct packed {
    logic [31:0] p;
    logic [31:0] m0;
    logic [31:0] m1;
    logic [31:0] m2;
    logic        dbl;
    logic [15:0] hi;
    logic [15:0] per;
  } row_type;

  // ****************************************
  // Cases: prescale, period, edges, double edge, high clocks, period clocks
  // ****************************************
  localparam row_type ROWS [6] = '{
    '{32'h0, 32'h3, 32'h1, 32'h0, 1'h0, 16'h2, 16'h4},
    '{32'h1, 32'h4, 32'h2, 32'h0, 1'h0, 16'h6, 16'ha},
    '{32'h2, 32'h9, 32'h0, 32'h0, 1'h0, 16'h3, 16'h1e},
    '{32'h0, 32'h9, 32'h2, 32'h6, 1'h1, 16'h4, 16'ha},
    '{32'h0, 32'h9, 32'h6, 32'h2, 1'h1, 16'h6, 16'ha},
    '{32'h0, 32'h7, 32'h6, 32'h0, 1'h0, 16'h7, 16'h8}
  };

  logic             clk;
  logic             srst;
  logic [7:0]       addr;
  logic [31:0]      wdata;
  logic             wr;
  logic             rd;
  logic [31:0]      rdata;
  logic             irq;
  logic [5:0]       pwm_out;
  logic [5:0]       pwm_oe;
  logic [5:0]       pin;
  logic [5:0][15:0] hi_len;
  logic [5:0][15:0] per_len;
  logic [5:0][7:0]  rises;
  logic [31:0]      d;
  logic [7:0]       snap;
  int               error_cnt;
  int               checked;

  match_based_pwm_unit uut (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .pwm_out(pwm_out), .pwm_oe(pwm_oe)
  );

  pwm_load load (
    .clk(clk), .srst(srst), .drv(pwm_out), .oe(pwm_oe), .pin(pin),
    .hi_len(hi_len), .per_len(per_len), .rises(rises)
  );

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic summarize;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_up;
    check(32'h0, 32'h1);
    summarize();
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    v = rdata;
  endtask

  task automatic wait_rises(input int ch, input int n);
    logic [7:0] start;
    int         k;
    start = rises[ch];
    k = 0;
    while (int'(8'(rises[ch] - start)) < n && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 2000) give_up();
  endtask

  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'h1 && k < 500) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 500) give_up();
  endtask

  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    give_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk = 1'h0;
    srst = 1'h1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'h0;
    rd = 1'h0;
    error_cnt = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    for (int i = 0; i < 6; i++) begin
      int ch;
      ch = ROWS[i].dbl ? 1 : 0;
      wr_reg(pwm_unit_pkg::OFS_TIMER_CTRL, 32'h2);
      wr_reg(pwm_unit_pkg::OFS_PRESCALE, ROWS[i].p);
      wr_reg(pwm_unit_pkg::OFS_MATCH_BASE, ROWS[i].m0);
      wr_reg(pwm_unit_pkg::OFS_MATCH_BASE + 8'h04, ROWS[i].m1);
      wr_reg(pwm_unit_pkg::OFS_MATCH_BASE + 8'h08, ROWS[i].m2);
      wr_reg(pwm_unit_pkg::OFS_PWM_CTRL, 32'h300 | {30'h0, ROWS[i].dbl, 1'h0});
      wr_reg(pwm_unit_pkg::OFS_TIMER_CTRL, 32'h9);
      wait_rises(ch, 3);
      check({16'h0, per_len[ch]}, {16'h0, ROWS[i].per});
      check({16'h0, hi_len[ch]}, {16'h0, ROWS[i].hi});
    end
    // Unreleased edge value must not act, released one at the next period
    wr_reg(pwm_unit_pkg::OFS_MATCH_BASE + 8'h04, 32'h2);
    wait_rises(0, 3);
    check({16'h0, hi_len[0]}, 32'h7);
    wr_reg(pwm_unit_pkg::OFS_RELEASE, 32'h2);
    rd_reg(pwm_unit_pkg::OFS_RELEASE, d);
    check(d, 32'h2);
    wait_rises(0, 3);
    check({16'h0, hi_len[0]}, 32'h3);
    rd_reg(pwm_unit_pkg::OFS_RELEASE, d);
    check(d, 32'h0);
    // Edge equal to period gives a constant low output
    wr_reg(pwm_unit_pkg::OFS_MATCH_BASE + 8'h04, 32'h7);
    wr_reg(pwm_unit_pkg::OFS_RELEASE, 32'h2);
    wait_rises(1, 2);
    snap = rises[0];
    wait_rises(1, 3);
    check({24'h0, rises[0]}, {24'h0, snap});
    check({31'h0, pin[0]}, 32'h0);
    // Interrupt raised, masked and cleared while counting continues
    wr_reg(pwm_unit_pkg::OFS_MATCH_CTRL, 32'h1);
    wr_reg(pwm_unit_pkg::OFS_INT_ENABLE, 32'h1);
    wait_irq();
    rd_reg(pwm_unit_pkg::OFS_INT_STATUS, d);
    check(d, 32'h1);
    wr_reg(pwm_unit_pkg::OFS_INT_ENABLE, 32'h0);
    #1;
    check({31'h0, irq}, 32'h0);
    wr_reg(pwm_unit_pkg::OFS_MATCH_CTRL, 32'h0);
    wr_reg(pwm_unit_pkg::OFS_INT_CLEAR, 32'h1);
    rd_reg(pwm_unit_pkg::OFS_INT_STATUS, d);
    check(d, 32'h0);
    // Plain timer: match 3 resets, stops and interrupts
    wr_reg(pwm_unit_pkg::OFS_TIMER_CTRL, 32'h2);
    wr_reg(pwm_unit_pkg::OFS_MATCH_BASE + 8'h0c, 32'h5);
    wr_reg(pwm_unit_pkg::OFS_MATCH_CTRL, 32'he00);
    wr_reg(pwm_unit_pkg::OFS_INT_ENABLE, 32'h8);
    wr_reg(pwm_unit_pkg::OFS_TIMER_CTRL, 32'h1);
    wait_irq();
    rd_reg(pwm_unit_pkg::OFS_COUNTER, d);
    check(d, 32'h0);
    rd_reg(pwm_unit_pkg::OFS_TIMER_CTRL, d);
    check(d, 32'h0);
    rd_reg(pwm_unit_pkg::OFS_INT_STATUS, d);
    check(d, 32'h8);
    // Full width counter and prescaler, unmapped place
    wr_reg(pwm_unit_pkg::OFS_COUNTER, 32'hffff_ffff);
    rd_reg(pwm_unit_pkg::OFS_COUNTER, d);
    check(d, 32'hffff_ffff);
    wr_reg(pwm_unit_pkg::OFS_PRESCALE, 32'hffff_ffff);
    rd_reg(pwm_unit_pkg::OFS_PRESCALE, d);
    check(d, 32'hffff_ffff);
    wr_reg(8'h80, 32'hffff_ffff);
    rd_reg(8'h80, d);
    check(d, 32'h0);
    // Reset with the timer stopped clears every register
    @(posedge clk);
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    for (int a = 0; a <= 8'h44; a += 4) begin
      rd_reg(8'(a), d);
      check(d, 32'h0);
    end
    check({25'h0, irq, pwm_oe}, 32'h0);
    summarize();
  end
endmodule

// ==== testbench/pwm_load.sv ====
`timescale 1ns/1ps

// ****************************************
// External loads on the six PWM pins
// ****************************************
module pwm_load (
  input  wire logic             clk,            // Peripheral clock
  input  wire logic             srst,           // Synchronous reset
  input  wire logic [5:0]       drv,            // Levels from the unit
  input  wire logic [5:0]       oe,             // Enables from the unit
  output logic      [5:0]       pin,            // Resolved pin levels
  output logic      [5:0][15:0] hi_len,         // Last high time in clocks
  output logic      [5:0][15:0] per_len,        // Last rise to rise time
  output logic      [5:0][7:0]  rises           // Rising edges seen
);
  logic [5:0]       pin_q;
  logic [5:0][15:0] hi_cnt;
  logic [5:0][15:0] per_cnt;

  // Pull-down wins when the pin is not driven
  assign pin = drv & oe;

  // Measure high time and period of every pin
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_q <= '0;
      hi_cnt <= '0;
      per_cnt <= '0;
      hi_len <= '0;
      per_len <= '0;
      rises <= '0;
    end else begin
      pin_q <= pin;
      for (int i = 0; i < 6; i++) begin
        per_cnt[i] <= per_cnt[i] + 16'h1;
        hi_cnt[i] <= pin[i] ? hi_cnt[i] + 16'h1 : 16'h0;
        if (pin[i] && !pin_q[i]) begin
          per_len[i] <= per_cnt[i];
          per_cnt[i] <= 16'h1;
          rises[i] <= rises[i] + 8'h1;
        end
        if (!pin[i] && pin_q[i]) begin
          hi_len[i] <= hi_cnt[i];
        end
      end
    end
  end
endmodule

// ==== testbench/pwm_unit_chk.sv ====
`timescale 1ns/1ps

// ****************************************
// Port checker for the match based PWM unit
// ****************************************
module pwm_unit_chk #(
  parameter int N_OUT = 6                       // Number of PWM outputs
) (
  input  wire logic             clk,            // Peripheral clock
  input  wire logic             srst,           // Synchronous reset
  input  wire logic [7:0]       addr,           // Register address
  input  wire logic [31:0]      wdata,          // Write data
  input  wire logic             wr,             // Write strobe
  input  wire logic             rd,             // Read strobe
  input  wire logic [31:0]      rdata,          // Read data
  input  wire logic             irq,            // Level interrupt
  input  wire logic [N_OUT-1:0] pwm_out,        // PWM levels
  input  wire logic [N_OUT-1:0] pwm_oe          // PWM output enables
);
  logic [N_OUT-1:0] wd_oe;
  logic             oe_wr;
  logic             mode_r;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // Decoded bus writes
  assign wd_oe = wdata[pwm_unit_pkg::PCTRL_OE_LSB +: N_OUT];
  assign oe_wr = wr && addr == pwm_unit_pkg::OFS_PWM_CTRL;

  // Mirror of the PWM mode bit
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_r <= 1'h0;
    end else if (wr && addr == pwm_unit_pkg::OFS_TIMER_CTRL) begin
      mode_r <= wdata[pwm_unit_pkg::TCTRL_PWM_BIT];
    end
  end

  AST_RDATA_IDLE: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not zero outside a read reply");
  AST_RESET_OUTS: assert property ($fell(srst) |-> rdata == 32'h0 && !irq && pwm_out == '0 && pwm_oe == '0)
    else $error("outputs not idle after reset");
  AST_OE_WRITE: assert property (oe_wr |=> pwm_oe == $past(wd_oe))
    else $error("output enables do not follow control write");
  AST_OE_HOLD: assert property ($changed(pwm_oe) |-> $past(oe_wr))
    else $error("output enables changed without a write");
  AST_IRQ_MASK: assert property (wr && addr == pwm_unit_pkg::OFS_INT_ENABLE && wdata[6:0] == 7'h00 |=> !irq)
    else $error("interrupt high with all enables off");
  AST_OUT_READ: assert property (rd && addr == pwm_unit_pkg::OFS_OUT_STATE |=>
    rdata[N_OUT-1:0] == $past(pwm_out) && rdata[31:N_OUT] == '0)
    else $error("output level readback wrong");
  AST_UNMAPPED: assert property (rd && addr > pwm_unit_pkg::OFS_OUT_STATE |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_STATUS_IRQ: assert property (rd && addr == pwm_unit_pkg::OFS_INT_STATUS && irq |=> rdata[6:0] != 7'h00)
    else $error("interrupt high with empty status");
  AST_RISE_MODE: assert property ((pwm_out & ~$past(pwm_out)) != '0 |-> $past(mode_r))
    else $error("output rose outside PWM mode");
endmodule

bind match_based_pwm_unit pwm_unit_chk #(.N_OUT(N_OUT)) chk (
  .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .irq(irq), .pwm_out(pwm_out), .pwm_oe(pwm_oe)
);
